/* File: src/urx_defines.svh */
/*
 Constants of the receive packet port: register offsets, field positions,
 reset values and access timing. Assumes a 25 ns clock.
*/
`ifndef URX_DEFINES_SVH
`define URX_DEFINES_SVH
// Clock period and access timing
`define URX_CLK_NS 25
`define URX_FIRST_NS 1218
`define URX_FIRST_CYC (`URX_FIRST_NS / `URX_CLK_NS)
`define URX_SEQ_NS 588
`define URX_SEQ_CYC (`URX_SEQ_NS / `URX_CLK_NS)
`define URX_HOLD_NS 2500
// Register byte offsets
`define URX_A_PTR_LO 8'h00
`define URX_A_PTR_HI 8'h04
`define URX_A_PNUM 8'h08
`define URX_A_DATA 8'h0C
`define URX_A_QUEUE 8'h10
`define URX_A_CMD 8'h14
`define URX_A_IRQ_ST 8'h18
`define URX_A_IRQ_MASK 8'h1C
// High pointer mode fields
`define URX_HI_HEAD 7
`define URX_HI_READ 6
`define URX_HI_STEP 5
// Queue register empty flag
`define URX_Q_EMPTY 7
// Memory commands
`define URX_CMD_KEEP 8'h01
`define URX_CMD_FREE 8'h02
// Header byte 0 fields and header byte offsets
`define URX_H0_CRC 4
`define URX_H0_PREV 5
`define URX_H0_SAME 6
`define URX_HDR_LEN 8'h08
`define URX_H_FRM_LO 1
`define URX_H_FRM_HI 2
`define URX_H_CNT_LO 6
`define URX_H_CNT_HI 7
// Interrupt status bits
`define URX_IRQ_RX 0
`define URX_IRQ_SOF 1
`define URX_IRQ_DROP 2
// Reset value of byte registers
`define URX_RST_BYTE 8'h00
`endif

/* File: src/urx_pkg.sv */
/*
 Types of the receive packet port. Assumes nothing of its surroundings.
*/
package urx_pkg;
	// Receive engine states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RECV = 4'h2,
		ST_DROP = 4'h4,
		ST_HDR = 4'h8
	} urx_state_t;
endpackage : urx_pkg

/* File: src/urx_rx_port.sv */
/*
 Receive packet port: packet buffer, receive queue, pointer registers and
 data window on a classic Wishbone slave (8-bit data).
 Assumes the serial engine runs on clk_i and spaces data bytes by two cycles.
*/
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "urx_defines.svh"
module urx_rx_port #(
	parameter int QDEPTH = 8,
	parameter int NPAGES = 32,
	parameter int PAGE_BYTES = 128
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic sel_i,
	input wire logic [7:0] dat_i,
	output logic [7:0] dat_o,
	output logic ack_o,
	input wire logic sie_start_i,
	input wire logic [3:0] sie_ep_i,
	input wire logic sie_valid_i,
	input wire logic [7:0] sie_data_i,
	input wire logic sie_end_i,
	input wire logic sie_crc_ok_i,
	input wire logic sie_toggle_i,
	input wire logic [10:0] sie_frame_i,
	input wire logic sie_sof_i,
	output logic sie_refuse_o,
	output logic irq_o
);
	localparam int PNW = $clog2(NPAGES);
	localparam int OFW = $clog2(PAGE_BYTES);
	localparam int QW = $clog2(QDEPTH);
	localparam int AW = PNW + OFW;
	localparam int FIRST_CYC = `URX_FIRST_CYC;
	localparam int SEQ_CYC = `URX_SEQ_CYC;
	localparam logic [7:0] MAXPAY = 8'(PAGE_BYTES - 8);

	logic [7:0] mem [0:NPAGES*PAGE_BYTES-1]; // Packet pages
	logic [PNW-1:0] q_mem [0:QDEPTH-1]; // Queued packet numbers
	logic [7:0] lo_r, lo_nxt; // Latched low pointer
	logic [7:0] hi_r, hi_nxt; // Mode fields of high pointer
	logic [OFW-1:0] off_r, off_nxt; // Applied byte offset
	logic [PNW-1:0] pns_r, pns_nxt; // Packet number select
	logic [NPAGES-1:0] free_r, free_nxt; // Free page pool
	logic [QW-1:0] qwp_r, qwp_nxt, qrp_r, qrp_nxt;
	logic [QW:0] qcnt_r, qcnt_nxt;
	logic [2:0] ist_r, ist_nxt, imask_r, imask_nxt; // Interrupt status/mask
	logic ack_r, ack_nxt;
	logic [7:0] dat_r, dat_nxt;
	urx_pkg::urx_state_t st_r, st_nxt;
	logic [PNW-1:0] page_r, page_nxt; // Page being filled
	logic [3:0] ep_r, ep_nxt;
	logic [7:0] cnt_r, cnt_nxt; // Payload byte count
	logic [7:0] hb0_r, hb0_nxt; // Header byte 0 under construction
	logic [10:0] frame_r, frame_nxt;
	logic [2:0] hidx_r, hidx_nxt; // Header write index
	logic [15:0] tog_r, tog_nxt; // Last toggle per endpoint
	logic acc, go, rd, wr, pop, push, q_empty, refuse, sie_we, drop_ev;
	logic [PNW-1:0] q_head, tgt_pn;
	logic mem_we;
	logic [AW-1:0] mem_wa, mcu_a;
	logic [7:0] mem_wd;

	// Lowest free page
	function automatic logic [PNW-1:0] first_free(input logic [NPAGES-1:0] f);
		logic [PNW-1:0] r;
		r = '0;
		for (int i = NPAGES - 1; i >= 0; i--) begin
			if (f[i]) begin
				r = PNW'(i);
			end
		end
		return r;
	endfunction : first_free

	// Header byte offset for each header write step
	function automatic logic [OFW-1:0] hdr_off(input logic [2:0] idx);
		logic [OFW-1:0] r;
		case (idx)
			3'h1: r = OFW'(`URX_H_FRM_LO);
			3'h2: r = OFW'(`URX_H_FRM_HI);
			3'h3: r = OFW'(`URX_H_CNT_LO);
			3'h4: r = OFW'(`URX_H_CNT_HI);
			default: r = '0;
		endcase
		return r;
	endfunction : hdr_off

	assign q_head = q_mem[qrp_r];
	assign q_empty = (qcnt_r == '0);
	// No page or a full queue shuts the port, setup packets included
	assign refuse = (qcnt_r == (QW+1)'(QDEPTH)) || (free_r == '0);
	assign tgt_pn = hi_r[`URX_HI_HEAD] ? q_head : pns_r;
	assign mcu_a = {tgt_pn, off_r};
	assign dat_o = dat_r;
	assign ack_o = ack_r;
	assign sie_refuse_o = refuse;
	assign irq_o = |(ist_r & imask_r);

	// Bus access: a window write waits while the engine owns the write port
	always_comb begin
		acc = cyc_i && stb_i && !ack_r;
		go = acc && !(we_i && adr_i == `URX_A_DATA && sie_we);
		rd = go && !we_i;
		wr = go && we_i && sel_i;
		pop = wr && !q_empty && (dat_i == `URX_CMD_KEEP || dat_i == `URX_CMD_FREE)
			&& adr_i == `URX_A_CMD;
		push = (st_r == urx_pkg::ST_HDR) && (hidx_r == 3'h4);
	end

	// Register file, queue pointers, interrupts and read data
	always_comb begin
		ack_nxt = go;
		lo_nxt = lo_r;
		hi_nxt = hi_r;
		off_nxt = off_r;
		pns_nxt = pns_r;
		imask_nxt = imask_r;
		dat_nxt = dat_r;
		qwp_nxt = push ? qwp_r + QW'(1) : qwp_r;
		qrp_nxt = pop ? qrp_r + QW'(1) : qrp_r;
		qcnt_nxt = qcnt_r + (QW+1)'(push) - (QW+1)'(pop);
		if (wr && adr_i == `URX_A_PTR_LO) begin
			lo_nxt = dat_i; // Held until the high half arrives
		end else if (wr && adr_i == `URX_A_PTR_HI) begin
			hi_nxt = dat_i;
			off_nxt = lo_r[OFW-1:0];
		end else if (wr && adr_i == `URX_A_PNUM) begin
			pns_nxt = dat_i[PNW-1:0];
		end else if (wr && adr_i == `URX_A_IRQ_MASK) begin
			imask_nxt = dat_i[2:0];
		end
		// Any window access steps the offset when asked
		if (go && adr_i == `URX_A_DATA && hi_r[`URX_HI_STEP]) begin
			off_nxt = off_r + OFW'(1);
		end
		if (rd) begin
			if (adr_i == `URX_A_PTR_LO) begin
				dat_nxt = lo_r;
			end else if (adr_i == `URX_A_PTR_HI) begin
				dat_nxt = hi_r;
			end else if (adr_i == `URX_A_PNUM) begin
				dat_nxt = 8'(pns_r);
			end else if (adr_i == `URX_A_DATA) begin
				dat_nxt = mem[mcu_a]; // Valid in the answer cycle
			end else if (adr_i == `URX_A_QUEUE) begin
				// An empty queue shows head zero, never an unwritten queue entry
				dat_nxt = q_empty ? 8'h00 : 8'(q_head);
				dat_nxt[`URX_Q_EMPTY] = q_empty;
			end else if (adr_i == `URX_A_IRQ_ST) begin
				dat_nxt = 8'(ist_r);
			end else if (adr_i == `URX_A_IRQ_MASK) begin
				dat_nxt = 8'(imask_r);
			end else begin
				dat_nxt = 8'h00; // Unmapped reads as zero
			end
		end
		// Read clears status, a new event in the same cycle survives
		ist_nxt = (rd && adr_i == `URX_A_IRQ_ST) ? 3'h0 : ist_r;
		ist_nxt[`URX_IRQ_RX] = ist_nxt[`URX_IRQ_RX] | push;
		ist_nxt[`URX_IRQ_SOF] = ist_nxt[`URX_IRQ_SOF] | sie_sof_i;
		ist_nxt[`URX_IRQ_DROP] = ist_nxt[`URX_IRQ_DROP] | drop_ev;
	end

	// Receive engine: allocate, store payload, then write the header
	always_comb begin
		st_nxt = st_r;
		page_nxt = page_r;
		ep_nxt = ep_r;
		cnt_nxt = cnt_r;
		hb0_nxt = hb0_r;
		frame_nxt = frame_r;
		hidx_nxt = hidx_r;
		tog_nxt = tog_r;
		free_nxt = free_r;
		drop_ev = 1'b0;
		sie_we = 1'b0;
		mem_wa = '0;
		mem_wd = 8'h00;
		case (st_r)
			urx_pkg::ST_IDLE: begin
				if (sie_start_i && refuse) begin
					st_nxt = urx_pkg::ST_DROP;
					drop_ev = 1'b1;
				end else if (sie_start_i) begin
					st_nxt = urx_pkg::ST_RECV;
					page_nxt = first_free(free_r);
					free_nxt[first_free(free_r)] = 1'b0;
					ep_nxt = sie_ep_i;
					frame_nxt = sie_frame_i;
					cnt_nxt = 8'h00;
				end
			end
			urx_pkg::ST_RECV: begin
				// Bytes beyond one page are discarded
				if (sie_valid_i && cnt_r < MAXPAY) begin
					sie_we = 1'b1;
					mem_wa = {page_r, OFW'(cnt_r + `URX_HDR_LEN)};
					mem_wd = sie_data_i;
					cnt_nxt = cnt_r + 8'h01;
				end
				if (sie_end_i) begin
					st_nxt = urx_pkg::ST_HDR;
					hidx_nxt = 3'h0;
					hb0_nxt = {4'h0, ep_r};
					hb0_nxt[`URX_H0_CRC] = !sie_crc_ok_i; // Stored anyway
					hb0_nxt[`URX_H0_PREV] = tog_r[ep_r];
					hb0_nxt[`URX_H0_SAME] = (sie_toggle_i == tog_r[ep_r]);
					tog_nxt[ep_r] = sie_toggle_i;
				end
			end
			urx_pkg::ST_DROP: begin
				if (sie_end_i) begin
					st_nxt = urx_pkg::ST_IDLE;
				end
			end
			urx_pkg::ST_HDR: begin
				sie_we = 1'b1;
				mem_wa = {page_r, hdr_off(hidx_r)};
				case (hidx_r)
					3'h0: mem_wd = hb0_r;
					3'h1: mem_wd = frame_r[7:0];
					3'h2: mem_wd = {5'h00, frame_r[10:8]};
					3'h3: mem_wd = cnt_r;
					default: mem_wd = 8'h00;
				endcase
				hidx_nxt = hidx_r + 3'h1;
				if (push) begin
					st_nxt = urx_pkg::ST_IDLE; // Queued even with bad CRC
				end
			end
			default: st_nxt = urx_pkg::ST_IDLE;
		endcase
		// Freeing the head returns its page, plain dequeue keeps it
		if (pop && dat_i == `URX_CMD_FREE) begin
			free_nxt[q_head] = 1'b1;
		end
		mem_we = sie_we || (wr && adr_i == `URX_A_DATA);
		if (!sie_we) begin
			mem_wa = mcu_a;
			mem_wd = dat_i;
		end
	end

	// State registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= `URX_RST_BYTE;
			lo_r <= `URX_RST_BYTE;
			hi_r <= `URX_RST_BYTE;
			off_r <= '0;
			pns_r <= '0;
			free_r <= '1;
			qwp_r <= '0;
			qrp_r <= '0;
			qcnt_r <= '0;
			ist_r <= 3'h0;
			imask_r <= 3'h0;
			st_r <= urx_pkg::ST_IDLE;
			page_r <= '0;
			ep_r <= 4'h0;
			cnt_r <= 8'h00;
			hb0_r <= 8'h00;
			frame_r <= 11'h000;
			hidx_r <= 3'h0;
			tog_r <= 16'h0000;
		end else begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			lo_r <= lo_nxt;
			hi_r <= hi_nxt;
			off_r <= off_nxt;
			pns_r <= pns_nxt;
			free_r <= free_nxt;
			qwp_r <= qwp_nxt;
			qrp_r <= qrp_nxt;
			qcnt_r <= qcnt_nxt;
			ist_r <= ist_nxt;
			imask_r <= imask_nxt;
			st_r <= st_nxt;
			page_r <= page_nxt;
			ep_r <= ep_nxt;
			cnt_r <= cnt_nxt;
			hb0_r <= hb0_nxt;
			frame_r <= frame_nxt;
			hidx_r <= hidx_nxt;
			tog_r <= tog_nxt;
		end
	end

	// Memory and queue storage carry no reset; head mode on an empty queue can use an unwritten queue entry, the window can read unwritten bytes
	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
		if (push) begin
			q_mem[qwp_r] <= page_r;
		end
	end

	a_first_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !we_i) |-> ##[0:FIRST_CYC] ack_o)
		else $error("read not answered in time");
	a_seq_access: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && adr_i == `URX_A_DATA) |-> ##[0:SEQ_CYC] ack_o)
		else $error("window access too slow");
	a_crc_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r == urx_pkg::ST_RECV && sie_end_i) |=>
		(mem_we && mem_wd[`URX_H0_CRC] == !$past(sie_crc_ok_i)) ##5 qcnt_r != '0)
		else $error("bad CRC packet not flagged or queued");
	a_ep_field: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r == urx_pkg::ST_RECV && sie_end_i) |=> mem_wd[3:0] == $past(ep_r))
		else $error("endpoint missing from header");
	a_free_head: assert property (@(posedge clk_i) disable iff (rst_i)
		(pop && dat_i == `URX_CMD_FREE) |=> free_r[$past(q_head)] && qrp_r != $past(qrp_r))
		else $error("dequeue-and-free failed");
	a_keep_mem: assert property (@(posedge clk_i) disable iff (rst_i)
		(pop && dat_i == `URX_CMD_KEEP && !(st_r == urx_pkg::ST_IDLE && sie_start_i)) |=>
		free_r == $past(free_r) && qrp_r != $past(qrp_r))
		else $error("plain dequeue changed memory");
	a_refuse_rx: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r == urx_pkg::ST_IDLE && sie_start_i && refuse) |=> st_r == urx_pkg::ST_DROP)
		else $error("packet accepted while exhausted");
	a_empty_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd && adr_i == `URX_A_QUEUE && q_empty) |=> dat_o[`URX_Q_EMPTY])
		else $error("empty flag missing");
	a_sof_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		sie_sof_i |=> ist_r[`URX_IRQ_SOF])
		else $error("frame start not latched");
	a_ptr_apply: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && adr_i == `URX_A_PTR_HI) |=> off_r == OFW'($past(lo_r)))
		else $error("pointer not applied");
endmodule : urx_rx_port

/* File: verif/urx_mcu_model.sv */
/*
 Controller model: classic Wishbone single cycles toward the port.
 Assumes an 8-bit slave on clk_i that answers with a one-cycle ack.
*/
`timescale 1ns/1ps
module urx_mcu_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [7:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic sel_o,
	output logic [7:0] dat_o
);
	int tmo = 0; // Answers that never came
	int lat = 0; // Cycles to ack of the last cycle
	// Quiet bus at time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 1'b0;
		dat_o = 8'h00;
	end
	// One bus cycle; request held until ack is sampled high or 64 cycles pass
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int i;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		dat_o <= d;
		sel_o <= 1'b1;
		lat = 0;
		for (i = 0; i < 64; i++) begin
			@(posedge clk_i);
			lat++;
			if (ack_i === 1'b1) break;
		end
		if (ack_i !== 1'b1) tmo++;
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
	endtask : xfer
	// Pointer pair, low half always first
	task automatic set_ptr(input logic [7:0] lo, input logic [7:0] hi);
		logic [7:0] q;
		xfer(1'b1, 8'h00, lo, q);
		xfer(1'b1, 8'h04, hi, q);
	endtask : set_ptr
endmodule : urx_mcu_model

/* File: verif/urx_rx_port_tb_top.sv */
/*
 Self-checking bench of the receive packet port.
 Assumes the port answers single Wishbone cycles and a 40 MHz clock.
*/
`timescale 1ns/1ps
module urx_rx_port_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, sel, ack, irq, refuse;
	logic [7:0] adr, wd, rdat;
	logic s_go = 1'b0;
	logic s_vld = 1'b0;
	logic s_end = 1'b0;
	logic s_ok = 1'b1;
	logic s_tg = 1'b0;
	logic s_sof = 1'b0;
	logic [3:0] s_ep = 4'h0;
	logic [7:0] s_dat = 8'h00;
	logic [10:0] s_fr = 11'h000;
	int err_count = 0;
	int n_checks = 0;
	logic [31:0] seed = 32'hA596;
	logic last_tog [16] = '{default: 1'b0}; // Toggle history per endpoint
	logic [7:0] ex [16]; // Expected packet bytes
	// Free-running clock, 25 ns
	initial forever #12.5 clk_i = ~clk_i;
	urx_rx_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack),
		.sie_start_i(s_go), .sie_ep_i(s_ep), .sie_valid_i(s_vld), .sie_data_i(s_dat),
		.sie_end_i(s_end), .sie_crc_ok_i(s_ok), .sie_toggle_i(s_tg),
		.sie_frame_i(s_fr), .sie_sof_i(s_sof), .sie_refuse_o(refuse), .irq_o(irq));
	urx_mcu_model i_mcu (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
		.stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Header byte 0 from what the engine reported
	function automatic logic [7:0] hdr0(input logic [3:0] ep, input logic ok,
		input logic pv, input logic tg);
		return {1'b0, tg == pv, pv, !ok, ep};
	endfunction : hdr0
	task automatic final_report();
		if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Bus wrappers; a lost answer ends the run
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		i_mcu.xfer(1'b0, a, 8'h00, q);
		if (i_mcu.tmo != 0) begin
			err_count++;
			final_report();
		end
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		i_mcu.xfer(1'b1, a, d, q);
		if (i_mcu.tmo != 0) begin
			err_count++;
			final_report();
		end
	endtask : wr
	// Engine side: bytes two cycles apart, then header write time
	task automatic send(input logic [3:0] ep, input int n, input logic ok,
		input logic tg, input logic [10:0] fr);
		int i;
		@(posedge clk_i);
		s_go <= 1'b1;
		s_ep <= ep;
		s_fr <= fr;
		@(posedge clk_i);
		s_go <= 1'b0;
		ex[0] = hdr0(ep, ok, last_tog[ep], tg);
		ex[1] = fr[7:0];
		ex[2] = {5'h00, fr[10:8]};
		ex[6] = n[7:0];
		ex[7] = 8'h00;
		for (i = 0; i < n; i++) begin
			seed = lfsr(seed);
			ex[8 + i] = seed[7:0];
			s_vld <= 1'b1;
			s_dat <= seed[7:0];
			@(posedge clk_i);
			s_vld <= 1'b0;
			@(posedge clk_i);
		end
		s_end <= 1'b1;
		s_ok <= ok;
		s_tg <= tg;
		@(posedge clk_i);
		s_end <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask : send
	initial begin
		logic [7:0] q;
		logic [7:0] kp, kn;
		int n, k, i;
		logic tg;
		logic [3:0] ep;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h10, q);
		chk("queue", 8'h80, q);
		rd(8'h20, q);
		chk("unmapped", 8'h00, q);
		wr(8'h1C, 8'h07);
		// Random packets, one bad CRC, one repeated toggle
		for (k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			n = 1 + seed[6:4];
			ep = seed[3:0];
			tg = (k == 2) ? last_tog[ep] : seed[7];
			send(ep, n, k != 1, tg, seed[18:8]);
			last_tog[ep] = tg;
			chk("irq", 8'h01, {7'h00, irq});
			rd(8'h18, q);
			chk("st_rx", 8'h01, q & 8'h01);
			chk("irq_clr", 8'h00, {7'h00, irq});
			i_mcu.set_ptr(8'h00, 8'hE0);
			for (i = 0; i < 8 + n; i++) begin
				rd(8'h0C, q);
				if (i < 3 || i > 5) chk("pkt", ex[i], q);
				chk("seq", 8'h01, {7'h00, i_mcu.lat <= 23});
			end
			rd(8'h10, q);
			chk("nonempty", 8'h00, q & 8'h80);
			if (k == 0) kp = q & 8'h1F;
			if (k == 0) kn = n[7:0];
			wr(8'h14, (k == 0) ? 8'h01 : 8'h02);
		end
		rd(8'h10, q);
		chk("drained", 8'h80, q & 8'h80);
		// Kept packet still readable by number
		wr(8'h08, kp);
		i_mcu.set_ptr(8'h06, 8'h60);
		rd(8'h0C, q);
		chk("kept", kn, q);
		i_mcu.set_ptr(8'h08, 8'h20);
		wr(8'h0C, 8'hA5);
		wr(8'h0C, 8'h5A);
		repeat (100) @(posedge clk_i);
		i_mcu.set_ptr(8'h08, 8'h60);
		rd(8'h0C, q);
		chk("wr0", 8'hA5, q);
		rd(8'h0C, q);
		chk("wr1", 8'h5A, q);
		// Frame start interrupt, masked then unmasked
		wr(8'h1C, 8'h00);
		@(posedge clk_i);
		s_sof <= 1'b1;
		@(posedge clk_i);
		s_sof <= 1'b0;
		@(posedge clk_i);
		chk("irq_mask", 8'h00, {7'h00, irq});
		wr(8'h1C, 8'h07);
		@(posedge clk_i);
		chk("irq_sof", 8'h01, {7'h00, irq});
		rd(8'h18, q);
		chk("st_sof", 8'h02, q);
		rd(8'h18, q);
		chk("st_once", 8'h00, q);
		// Fill the queue until the port refuses
		for (k = 0; k < 8; k++) send(4'h3, 1, 1'b1, 1'b0, 11'h7FF);
		chk("refuse", 8'h01, {7'h00, refuse});
		rd(8'h18, q);
		send(4'h0, 2, 1'b1, 1'b0, 11'h001);
		rd(8'h18, q);
		chk("st_drop", 8'h04, q & 8'h04);
		for (k = 0; k < 8; k++) wr(8'h14, 8'h02);
		rd(8'h10, q);
		chk("empty", 8'h80, q & 8'h80);
		chk("accept", 8'h00, {7'h00, refuse});
		final_report();
	end
endmodule : urx_rx_port_tb_top
